/* File: hw/uc2_channel.sv */
// Second asynchronous serial channel: registers, baud timing, transmitter, receiver, pins
`include "uc2_params.svh"

// Overview of operation
// [RL1] Mode 0: parity type bit clear gives even parity, set gives odd, both ways.
// [RL2] Mode 0: parity enable clear omits parity; set inserts and checks it.
// [RL3] Mode 1 ignores both parity bits; frames carry no parity bit.
// [RL4] Wakeup flag sets while wakeup enable is one and receive pin is low.
// [RL5] Wakeup enable and wakeup flag both one raise the interrupt request.
// [RL6] Each transmission starts by moving the transmit holding byte into the shifter.
// [RL7] Software writes a new transmit byte only after seeing the empty flag set.
// [RL8] Each reception ends by copying the receive shifter into receive holding.
// [RL9] Mode 0 bit period is (divider plus one) times 4, or 16 when selected.
// [RL10] Divider zero selects mode 1; any nonzero divider selects mode 0.
// [RL11] Transmit pin drives serial output as CMOS, slow CMOS or open drain.
// [RL12] Receive pin feeds the receiver only when all four select bits are one.
// [RL13] Mode 1 runs at 9600 bit/s and ignores the division select.
// [RL14] Empty flag sets when holding moves to shifter, clears on holding write.
// [RL15] Receive-complete flag sets at the stop bit, clears on holding read.
// [RL16] Characters carry eight data bits, least significant bit first.
// [RL17] Line idles high; low start, data, optional parity, high stop bits.
// [RL18] Receiver samples each bit mid-period, timed from the start bit edge.
module uc2_channel #(
	// Bit period of mode 1; a short value keeps simulation quick
	parameter logic [15:0] MODE1_BIT_CYCLES = 16'(`UC2_MODE1_BIT_CYCLES)
) (
	// Clock, reset and freeze
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	// Register port
	input  wire uc2_pkg::uc2_bus_req_t bus_req,
	output logic [7:0]             reg_rdata,
	// Interrupt request
	output logic                   irq,
	// Serial pins
	input  wire logic              rx_pin_in,
	output logic                   tx_pin_out,
	output logic                   tx_pin_oe_n,
	output logic                   tx_pin_slow
);

	// Bit period in system clock cycles for the current divider and division select
	// Zero divider means mode 1, whose fixed period ignores the division select
	function automatic logic [15:0] uc2_period(input logic [7:0] dv, input logic d16);
		logic [15:0] base;
		// Widened first so that a divider of 255 times 16 does not wrap
		base = {8'h00, dv} + 16'h0001;
		if (dv == 8'h00) begin
			uc2_period = MODE1_BIT_CYCLES; // [RL10] [RL13]
		end else if (d16) begin
			uc2_period = 16'(base << `UC2_MUL_SHIFT_X16); // [RL9]
		end else begin
			uc2_period = 16'(base << `UC2_MUL_SHIFT_X4); // [RL9]
		end
	endfunction : uc2_period

	uc2_pkg::uc2_state_t s_r;
	uc2_pkg::uc2_state_t s_nxt;

	// Decoded settings shared by transmitter and receiver
	logic        mode1;
	logic        par_on;
	logic [15:0] period;
	logic        rxd;
	// Line level the transmitter wants before the pin function is applied
	logic        tx_line;
	// Events of this cycle, merged into the sticky status below
	logic [4:0]  ev;

	// Derived mode, parity and serial input
	// Parity exists only in mode 0
	assign mode1  = (s_r.divider == 8'h00); // [RL10]
	assign par_on = !mode1 && s_r.par_en; // [RL2] [RL3]
	assign period = uc2_period(s_r.divider, s_r.div16);
	// Receiver sees an idle high line unless the pin is set up for it
	assign rxd    = (s_r.rx_pin == 4'b1111) ? s_r.rx_sync : 1'b1; // [RL12]

	// Next state of the whole channel
	always_comb begin
		s_nxt   = s_r;
		ev      = 5'b0_0000;
		tx_line = 1'b1;

		// Two-stage synchroniser for the receive pin
		// Only the second stage feeds logic
		s_nxt.rx_meta = rx_pin_in;
		s_nxt.rx_sync = s_r.rx_meta;

		// Read data for the cycle after a read strobe; unmapped reads give zero
		s_nxt.rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`UC2_OFF_CTRL: begin
					s_nxt.rdata = {s_r.stop2, s_r.div16, 2'b00, s_r.par_odd, s_r.par_en,
						s_r.wake_flag, s_r.wake_ie};
				end
				`UC2_OFF_TX_HOLD:    s_nxt.rdata = s_r.tx_hold;
				`UC2_OFF_RX_HOLD: begin
					s_nxt.rdata    = s_r.rx_hold;
					s_nxt.rx_ready = 1'b0; // [RL15]
				end
				`UC2_OFF_DIVIDER:    s_nxt.rdata = s_r.divider;
				`UC2_OFF_IRQ_STATUS: s_nxt.rdata = {3'b000, s_r.irq_stat};
				`UC2_OFF_IRQ_MASK:   s_nxt.rdata = {3'b000, s_r.irq_mask};
				`UC2_OFF_PIN_CFG:    s_nxt.rdata = {s_r.rx_pin, s_r.tx_pin};
				// Live flags and busy bits for polling software
				`UC2_OFF_FLAGS: begin
					s_nxt.rdata = {4'h0, s_r.rx_state != uc2_pkg::RX_IDLE,
						s_r.tx_state != uc2_pkg::TX_IDLE, s_r.tx_empty, s_r.rx_ready};
				end
				default:             s_nxt.rdata = 8'h00;
			endcase
		end

		// Transmitter; a bit lasts one period counted down to zero
		case (s_r.tx_state)
			// Idle: a pending holding byte starts the next frame
			uc2_pkg::TX_IDLE: begin
				if (!s_r.tx_empty) begin
					s_nxt.tx_shift = s_r.tx_hold; // [RL6]
					s_nxt.tx_empty = 1'b1; // [RL14]
					ev[`UC2_EV_TX_EMPTY] = 1'b1;
					s_nxt.tx_cnt   = period - 16'h0001;
					s_nxt.tx_par   = 1'b0;
					s_nxt.tx_state = uc2_pkg::TX_START;
				end
			end

			// Start bit: one period low
			uc2_pkg::TX_START: begin
				tx_line = 1'b0; // [RL17]
				s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_cnt   = period - 16'h0001;
					s_nxt.tx_bit   = 3'd0;
					s_nxt.tx_state = uc2_pkg::TX_DATA;
				end
			end

			// Data: shift out least significant bit first, folding parity
			uc2_pkg::TX_DATA: begin
				tx_line = s_r.tx_shift[0]; // [RL16]
				s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_cnt   = period - 16'h0001;
					s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
					s_nxt.tx_par   = s_r.tx_par ^ s_r.tx_shift[0];
					s_nxt.tx_bit   = s_r.tx_bit + 3'd1;
					if (s_r.tx_bit == 3'd7) begin
						s_nxt.tx_stop_more = s_r.stop2;
						s_nxt.tx_state = par_on ? uc2_pkg::TX_PARITY : uc2_pkg::TX_STOP; // [RL2] [RL3]
					end
				end
			end

			// Parity bit, present only in mode 0 with parity enabled
			uc2_pkg::TX_PARITY: begin
				// Even parity makes the count of ones even, odd parity makes it odd
				tx_line = s_r.tx_par ^ s_r.par_odd; // [RL1]
				s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_cnt   = period - 16'h0001;
					s_nxt.tx_state = uc2_pkg::TX_STOP;
				end
			end

			// Stop: one period high, or two when the long stop is chosen
			uc2_pkg::TX_STOP: begin
				tx_line = 1'b1; // [RL17]
				s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_cnt = period - 16'h0001;
					if (s_r.tx_stop_more) begin
						s_nxt.tx_stop_more = 1'b0;
					end else begin
						ev[`UC2_EV_TX_END] = s_r.tx_empty;
						s_nxt.tx_state = uc2_pkg::TX_IDLE;
					end
				end
			end
			default: s_nxt.tx_state = uc2_pkg::TX_IDLE;
		endcase

		// Receiver; start is checked at half a period, later bits at their middle
		case (s_r.rx_state)
			// Idle: a low line is a possible start edge
			uc2_pkg::RX_IDLE: begin
				if (!rxd) begin
					s_nxt.rx_cnt   = {1'b0, period[15:1]}; // [RL18]
					s_nxt.rx_state = uc2_pkg::RX_START;
				end
			end

			// Start: confirm the low level at half a period
			uc2_pkg::RX_START: begin
				s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
				if (s_r.rx_cnt == 16'h0000) begin
					// A start bit that is high again at its middle was a glitch
					if (!rxd) begin
						s_nxt.rx_cnt   = period - 16'h0001;
						s_nxt.rx_bit   = 3'd0;
						s_nxt.rx_par   = 1'b0;
						s_nxt.rx_perr  = 1'b0;
						s_nxt.rx_state = uc2_pkg::RX_DATA; // [RL17]
					end else begin
						s_nxt.rx_state = uc2_pkg::RX_IDLE;
					end
				end
			end

			// Data: sample mid-bit, least significant bit first
			uc2_pkg::RX_DATA: begin
				s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
				if (s_r.rx_cnt == 16'h0000) begin
					s_nxt.rx_cnt   = period - 16'h0001;
					s_nxt.rx_shift = {rxd, s_r.rx_shift[7:1]}; // [RL16]
					s_nxt.rx_par   = s_r.rx_par ^ rxd;
					s_nxt.rx_bit   = s_r.rx_bit + 3'd1;
					if (s_r.rx_bit == 3'd7) begin
						s_nxt.rx_state = par_on ? uc2_pkg::RX_PARITY : uc2_pkg::RX_STOP; // [RL2] [RL3]
					end
				end
			end

			// Parity: compare against the folded data bits
			uc2_pkg::RX_PARITY: begin
				s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
				if (s_r.rx_cnt == 16'h0000) begin
					s_nxt.rx_cnt   = period - 16'h0001;
					s_nxt.rx_perr  = rxd ^ s_r.rx_par ^ s_r.par_odd; // [RL1] [RL2]
					s_nxt.rx_state = uc2_pkg::RX_STOP;
				end
			end

			// Stop: hand the byte over and report the outcome
			uc2_pkg::RX_STOP: begin
				s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
				if (s_r.rx_cnt == 16'h0000) begin
					// Only the first stop bit is checked; a second one may be a new start
					s_nxt.rx_hold  = s_r.rx_shift; // [RL8]
					s_nxt.rx_ready = 1'b1; // [RL15]
					ev[`UC2_EV_RX_DONE] = 1'b1;
					// Parity, framing and overrun errors share one status bit
					ev[`UC2_EV_RX_ERR]  = s_r.rx_perr | !rxd | s_r.rx_ready;
					s_nxt.rx_state = uc2_pkg::RX_IDLE;
				end
			end
			default: s_nxt.rx_state = uc2_pkg::RX_IDLE;
		endcase

		// Register writes
		// Writes come after the engines so software settings take this cycle's say
		if (bus_req.wr) begin
			case (bus_req.addr)
				`UC2_OFF_CTRL: begin
					s_nxt.stop2     = bus_req.wdata[`UC2_CTRL_STOP2];
					s_nxt.div16     = bus_req.wdata[`UC2_CTRL_DIV16];
					s_nxt.par_odd   = bus_req.wdata[`UC2_CTRL_ODD];
					s_nxt.par_en    = bus_req.wdata[`UC2_CTRL_PAR_EN];
					s_nxt.wake_flag = bus_req.wdata[`UC2_CTRL_WAKE_FLAG];
					s_nxt.wake_ie   = bus_req.wdata[`UC2_CTRL_WAKE_IE];
				end
				`UC2_OFF_TX_HOLD: begin
					// A byte written while the old one moves out stays pending
					s_nxt.tx_hold  = bus_req.wdata;
					s_nxt.tx_empty = 1'b0; // [RL14] [RL7]
				end
				`UC2_OFF_DIVIDER:    s_nxt.divider  = bus_req.wdata; // [RL10]
				// Status bits clear where a one is written
				`UC2_OFF_IRQ_STATUS: s_nxt.irq_stat = s_r.irq_stat & ~bus_req.wdata[4:0];
				`UC2_OFF_IRQ_MASK:   s_nxt.irq_mask = bus_req.wdata[4:0];
				`UC2_OFF_PIN_CFG: begin
					s_nxt.tx_pin = bus_req.wdata[3:0];
					s_nxt.rx_pin = bus_req.wdata[7:4];
				end
				default: s_nxt.divider = s_nxt.divider;
			endcase
		end

		// Wakeup detection watches the pin itself; set wins over a software clear
		// Wakeup works even while the receive pin is not routed to the receiver
		if (s_r.wake_ie && !s_r.rx_sync) begin
			s_nxt.wake_flag = 1'b1; // [RL4]
			ev[`UC2_EV_WAKE] = 1'b1;
		end

		// Sticky events, set after any clear in the same cycle
		// so an event is never lost to a clear that races it
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		s_nxt.irq = (|(s_nxt.irq_stat & s_nxt.irq_mask))
			| (s_nxt.wake_ie & s_nxt.wake_flag); // [RL5]

		// Transmit pin function; open drain only pulls low
		s_nxt.tx_out  = 1'b0;
		s_nxt.tx_oe_n = 1'b1;
		s_nxt.tx_slow = 1'b0;
		if (s_r.tx_pin.fsa) begin
			case ({s_r.tx_pin.fsb, s_r.tx_pin.lat, s_r.tx_pin.ddr})
				// Push-pull output
				3'b001: begin
					s_nxt.tx_out  = tx_line; // [RL11]
					s_nxt.tx_oe_n = 1'b0;
				end
				// Push-pull with slow edges for long lines
				3'b110: begin
					s_nxt.tx_out  = tx_line; // [RL11]
					s_nxt.tx_oe_n = 1'b0;
					s_nxt.tx_slow = 1'b1;
				end
				// Open drain: released for a one, relies on an outside pull-up
				3'b101: begin
					s_nxt.tx_out  = 1'b0; // [RL11]
					s_nxt.tx_oe_n = tx_line;
				end
				default: s_nxt.tx_oe_n = 1'b1;
			endcase
		end
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r           <= '0;
			// Synchroniser and line start at idle high, pin released
			s_r.rx_meta   <= 1'b1;
			s_r.rx_sync   <= 1'b1;
			s_r.tx_empty  <= 1'b1;
			s_r.tx_oe_n   <= 1'b1;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	// Registered so the pins never glitch on decode changes
	assign reg_rdata   = s_r.rdata;
	assign irq         = s_r.irq;
	assign tx_pin_out  = s_r.tx_out;
	assign tx_pin_oe_n = s_r.tx_oe_n;
	assign tx_pin_slow = s_r.tx_slow;

endmodule : uc2_channel

/* File: hw/uc2_params.svh */
// Register offsets, field positions, reset values and timing counts of the serial channel
`ifndef UC2_PARAMS_SVH
`define UC2_PARAMS_SVH

// Register offsets on the register port
`define UC2_OFF_CTRL        16'h7f6d
`define UC2_OFF_TX_HOLD     16'h7f6e
`define UC2_OFF_RX_HOLD     16'h7f6f
`define UC2_OFF_DIVIDER     16'h7f74
`define UC2_OFF_IRQ_STATUS  16'h7f76
`define UC2_OFF_IRQ_MASK    16'h7f77
`define UC2_OFF_PIN_CFG     16'h7f78
`define UC2_OFF_FLAGS       16'h7f79

// Control register field positions
`define UC2_CTRL_STOP2      7
`define UC2_CTRL_DIV16      6
`define UC2_CTRL_ODD        3
`define UC2_CTRL_PAR_EN     2
`define UC2_CTRL_WAKE_FLAG  1
`define UC2_CTRL_WAKE_IE    0

// Event status and mask field positions
`define UC2_EV_RX_DONE      0
`define UC2_EV_TX_EMPTY     1
`define UC2_EV_TX_END       2
`define UC2_EV_RX_ERR       3
`define UC2_EV_WAKE         4
`define UC2_EV_W            5

// Reset values
`define UC2_RST_HOLD        8'h00
`define UC2_RST_DIVIDER     8'h00
`define UC2_RST_PIN_CFG     8'h00

// Mode 0 period multipliers, written as shift amounts (x4 and x16)
`define UC2_MUL_SHIFT_X4    2
`define UC2_MUL_SHIFT_X16   4

// Mode 1 timing: the bit period is taken from the system clock
`define UC2_CLK_HZ          100000000
`define UC2_MODE1_BPS       9600
`define UC2_MODE1_BIT_CYCLES (`UC2_CLK_HZ / `UC2_MODE1_BPS)

`endif

/* File: hw/uc2_pkg.sv */
// Types shared by the serial channel: bus request, pin setup, states and the state record
package uc2_pkg;

	// Register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} uc2_bus_req_t;

	// Function select, latch and direction bits of one pin
	typedef struct packed {
		logic fsa;
		logic fsb;
		logic lat;
		logic ddr;
	} uc2_pin_sel_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uc2_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uc2_rx_state_t;

	// Whole state of the channel
	typedef struct packed {
		logic          rx_meta;
		logic          rx_sync;
		logic [7:0]    tx_hold;
		logic [7:0]    rx_hold;
		logic [7:0]    divider;
		logic          stop2;
		logic          div16;
		logic          par_odd;
		logic          par_en;
		logic          wake_flag;
		logic          wake_ie;
		uc2_pin_sel_t  tx_pin;
		uc2_pin_sel_t  rx_pin;
		logic [4:0]    irq_stat;
		logic [4:0]    irq_mask;
		logic          tx_empty;
		logic          rx_ready;
		uc2_tx_state_t tx_state;
		logic [15:0]   tx_cnt;
		logic [2:0]    tx_bit;
		logic [7:0]    tx_shift;
		logic          tx_par;
		logic          tx_stop_more;
		uc2_rx_state_t rx_state;
		logic [15:0]   rx_cnt;
		logic [2:0]    rx_bit;
		logic [7:0]    rx_shift;
		logic          rx_par;
		logic          rx_perr;
		logic [7:0]    rdata;
		logic          irq;
		logic          tx_out;
		logic          tx_oe_n;
		logic          tx_slow;
	} uc2_state_t;

endpackage : uc2_pkg

/* File: verif/uc2_channel_bench.sv */
// Self-checking bench of the second serial channel
`include "uc2_params.svh"
module uc2_channel_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// Divider, control and resulting bit period of each transmit case
	localparam logic [7:0] DIV [5] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h00};
	localparam logic [7:0] CTL [5] = '{8'h80, 8'h04, 8'h0c, 8'h44, 8'h4c};
	localparam int         PER [5] = '{8, 8, 8, 48, 16};
	// Transmit pin setups and expected {oe_n, slow}
	localparam logic [3:0] PIN [4] = '{4'h9, 4'he, 4'hd, 4'h1};
	localparam logic [7:0] PEX [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
	logic                  clock = 1'b0;
	logic                  resetn = 1'b0;
	logic                  clk_en = 1'b1;
	uc2_pkg::uc2_bus_req_t bus_req = '0;
	logic [7:0]            reg_rdata;
	logic                  irq;
	logic                  tx_pin_out;
	logic                  tx_pin_oe_n;
	logic                  tx_pin_slow;
	logic                  rx_line;
	logic [7:0]            v;
	logic [7:0]            b;
	int                    err_total = 0;
	int                    tests_run = 0;
	// Line has a pull-up, so a released pin reads high
	wire tx_wire = tx_pin_oe_n ? 1'b1 : tx_pin_out;

	always #5 clock = ~clock;

	uc2_channel #(.MODE1_BIT_CYCLES(16'h0010)) i_uc2_channel (
		.clock(clock), .resetn(resetn), .clk_en(clk_en), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .irq(irq), .rx_pin_in(rx_line), .tx_pin_out(tx_pin_out),
		.tx_pin_oe_n(tx_pin_oe_n), .tx_pin_slow(tx_pin_slow)
	);
	uc2_peer i_uc2_peer (.clock(clock), .tx_wire(tx_wire), .rx_line(rx_line));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// One request cycle then idle; read data stands in the following cycle
	task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clock);
		bus_req <= '0;
		#1 v = reg_rdata;
	endtask : bus
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		bus(a, 8'h00, 1'b0);
		check(v, exp);
	endtask : rd
	// Request output is registered from next-state values, so it already follows the write; one more edge is waited anyway
	task automatic chk_irq(input logic exp);
		@(posedge clock);
		#1 check({7'h00, irq}, {7'h00, exp});
	endtask : chk_irq
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// Watchdog well beyond the roughly 1500 cycles the sequence needs
	initial begin
		#200000;
		err_total++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		// Reset values, an unmapped place, a read-only holding register
		rd(`UC2_OFF_TX_HOLD, 8'h00);
		rd(`UC2_OFF_DIVIDER, 8'h00);
		rd(`UC2_OFF_FLAGS, 8'h02);
		rd(16'h7f70, 8'h00);
		bus(`UC2_OFF_RX_HOLD, 8'h5a, 1'b1);
		rd(`UC2_OFF_RX_HOLD, 8'h00);
		// Every transmit pin setup, and one that leaves it released
		for (int n = 0; n < 4; n++) begin
			bus(`UC2_OFF_PIN_CFG, {4'hf, PIN[n]}, 1'b1);
			repeat (2) @(posedge clock);
			#1 check({6'h00, tx_pin_oe_n, tx_pin_slow}, PEX[n]);
		end
		bus(`UC2_OFF_PIN_CFG, 8'hf9, 1'b1);
		// Two stops, even, odd, divide by 16, then mode 1 with parity bits ignored
		for (int n = 0; n < 5; n++) begin
			b = 8'h33 + 8'(n);
			bus(`UC2_OFF_DIVIDER, DIV[n], 1'b1);
			rd(`UC2_OFF_DIVIDER, DIV[n]);
			bus(`UC2_OFF_CTRL, CTL[n], 1'b1);
			i_uc2_peer.bit_p = PER[n];
			i_uc2_peer.par_on = CTL[n][2] && DIV[n] != 8'h00;
			rd(`UC2_OFF_FLAGS, 8'h02);
			bus(`UC2_OFF_TX_HOLD, b, 1'b1);
			rd(`UC2_OFF_FLAGS, 8'h06);
			repeat (12 * PER[n]) @(posedge clock);
			check(i_uc2_peer.got, b);
			check(8'(i_uc2_peer.frames), 8'(n + 1));
			if (i_uc2_peer.par_on) check({7'h00, i_uc2_peer.got_par}, {7'h00, ^b ^ CTL[n][3]});
		end
		check(8'(i_uc2_peer.errs), 8'h00);
		// Receive, raise, mask and clear the receive event, then a parity error
		bus(`UC2_OFF_DIVIDER, 8'h01, 1'b1);
		bus(`UC2_OFF_CTRL, 8'h04, 1'b1);
		i_uc2_peer.bit_p = 8;
		i_uc2_peer.par_on = 1'b1;
		bus(`UC2_OFF_IRQ_STATUS, 8'h1f, 1'b1);
		i_uc2_peer.send(8'hc5, 1'b0, 1'b0);
		chk_irq(1'b0);
		rd(`UC2_OFF_IRQ_STATUS, 8'h01);
		bus(`UC2_OFF_IRQ_MASK, 8'h01, 1'b1);
		chk_irq(1'b1);
		rd(`UC2_OFF_RX_HOLD, 8'hc5);
		rd(`UC2_OFF_FLAGS, 8'h02);
		bus(`UC2_OFF_IRQ_STATUS, 8'h01, 1'b1);
		chk_irq(1'b0);
		i_uc2_peer.send(8'hc5, 1'b0, 1'b1);
		rd(`UC2_OFF_IRQ_STATUS, 8'h09);
		// A frame on a receive pin that is not routed to the receiver
		bus(`UC2_OFF_PIN_CFG, 8'h79, 1'b1);
		bus(`UC2_OFF_IRQ_STATUS, 8'h1f, 1'b1);
		i_uc2_peer.send(8'hc5, 1'b0, 1'b0);
		rd(`UC2_OFF_IRQ_STATUS, 8'h00);
		bus(`UC2_OFF_PIN_CFG, 8'hf9, 1'b1);
		// A write while the clock enable is low is not taken
		@(posedge clock) clk_en <= 1'b0;
		bus(`UC2_OFF_DIVIDER, 8'h7e, 1'b1);
		clk_en <= 1'b1;
		rd(`UC2_OFF_DIVIDER, 8'h01);
		// A low receive pin with wakeup enabled
		bus(`UC2_OFF_IRQ_MASK, 8'h00, 1'b1);
		bus(`UC2_OFF_CTRL, 8'h01, 1'b1);
		@(posedge clock) i_uc2_peer.rx_line <= 1'b0;
		repeat (4) @(posedge clock);
		rd(`UC2_OFF_CTRL, 8'h03);
		chk_irq(1'b1);
		@(posedge clock) i_uc2_peer.rx_line <= 1'b1;
		finish_test();
	end
endmodule : uc2_channel_bench

/* File: verif/uc2_channel_monitor.sv */
// Port checker of the second serial channel, bound to its top module
`include "uc2_params.svh"
module uc2_channel_monitor (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  resetn,
	input wire logic                  clk_en,
	// Register port
	input wire uc2_pkg::uc2_bus_req_t bus_req,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  irq,
	// Serial pins
	input wire logic                  rx_pin_in,
	input wire logic                  tx_pin_out,
	input wire logic                  tx_pin_oe_n,
	input wire logic                  tx_pin_slow
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Requests taken at this edge; a frozen edge takes nothing
	wire rd_flags = clk_en && bus_req.rd && bus_req.addr == `UC2_OFF_FLAGS;
	wire rd_rx    = clk_en && bus_req.rd && bus_req.addr == `UC2_OFF_RX_HOLD;
	wire rd_ctrl  = clk_en && bus_req.rd && bus_req.addr == `UC2_OFF_CTRL;
	wire rd_div   = clk_en && bus_req.rd && bus_req.addr == `UC2_OFF_DIVIDER;
	wire wr_div   = clk_en && bus_req.wr && bus_req.addr == `UC2_OFF_DIVIDER;
	wire wr_tx    = clk_en && bus_req.wr && bus_req.addr == `UC2_OFF_TX_HOLD;

	property p_reset_pins;
		$rose(resetn) |-> tx_pin_oe_n && !irq && reg_rdata == 8'h00;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("Pins busy after reset");
	property p_tx_start;
		rd_flags ##1 !reg_rdata[2] ##1 wr_tx |-> ##[2:3] (tx_pin_oe_n || !tx_pin_out);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("No start bit after write");
	property p_div_back;
		wr_div ##2 rd_div |=> reg_rdata == $past(bus_req.wdata, 3);
	endproperty
	a_div_back: assert property (p_div_back) else $error("Divider read back wrong");
	property p_rx_clear;
		rd_rx ##2 rd_flags |=> !reg_rdata[0];
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("Receive flag kept");
	property p_wake_irq;
		rd_ctrl ##1 reg_rdata[1:0] == 2'b11 |-> ##[0:2] irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("Wakeup request missing");
	// Shortest legal bit period is eight cycles, so no level run is shorter
	property p_low_min;
		$fell(tx_pin_out) && !tx_pin_oe_n |=> (!tx_pin_out) [*7];
	endproperty
	a_low_min: assert property (p_low_min) else $error("Low bit too short");
	property p_high_min;
		$rose(tx_pin_out) && !tx_pin_oe_n && !$past(tx_pin_oe_n) |=> tx_pin_out [*7];
	endproperty
	a_high_min: assert property (p_high_min) else $error("High bit too short");
	property p_slow_drives;
		tx_pin_slow |-> !tx_pin_oe_n;
	endproperty
	a_slow_drives: assert property (p_slow_drives) else $error("Slow pin not driven");
endmodule : uc2_channel_monitor

bind uc2_channel uc2_channel_monitor i_uc2_channel_monitor (
	.clock(clock), .resetn(resetn), .clk_en(clk_en), .bus_req(bus_req),
	.reg_rdata(reg_rdata), .irq(irq), .rx_pin_in(rx_pin_in),
	.tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n), .tx_pin_slow(tx_pin_slow)
);

/* File: verif/uc2_peer.sv */
// Remote serial peer: sends frames to the receive pin, decodes the transmit wire
module uc2_peer (
	// Clock and lines
	input  wire logic clock,
	input  wire logic tx_wire,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bit_p = 8;
	logic       par_on = 1'b0;
	logic [7:0] got;
	logic       got_par;
	int         frames = 0;
	int         errs = 0;
	initial rx_line = 1'b1;
	// One frame; bad turns the parity bit round on purpose
	task automatic send(input logic [7:0] d, input logic odd, input logic bad);
		logic [9:0] f;
		f = {1'b1, ^d ^ odd ^ bad, d};
		if (!par_on) f[8] = 1'b1;
		@(posedge clock) rx_line <= 1'b0;
		repeat (bit_p) @(posedge clock);
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (bit_p) @(posedge clock);
		end
	endtask : send
	// Sample mid-bit from the start edge; a low stop counts as a frame error
	always begin
		@(negedge tx_wire);
		repeat (bit_p / 2) @(posedge clock);
		if (tx_wire !== 1'b0) errs++;
		for (int i = 0; i < 8; i++) begin
			repeat (bit_p) @(posedge clock);
			got[i] = tx_wire;
		end
		if (par_on) begin
			repeat (bit_p) @(posedge clock);
			got_par = tx_wire;
		end
		repeat (bit_p) @(posedge clock);
		if (tx_wire !== 1'b1) errs++;
		frames++;
	end
endmodule : uc2_peer
